/* File: logic/iad_map.svh */
// Register offsets, field positions and reset values of the address-match status block
`ifndef IAD_MAP_SVH
`define IAD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IAD_OFS_CTRL   8'h00
`define IAD_OFS_STATUS 8'h01
`define IAD_OFS_SADDR  8'h02
`define IAD_OFS_DATA   8'h03
`define IAD_OFS_INTST  8'h04
`define IAD_OFS_INTMSK 8'h05

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define IAD_CTL_ON    7
`define IAD_CTL_LEAVE 6
`define IAD_CTL_WREL  5

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define IAD_ST_MSTS 7
`define IAD_ST_ALD  6
`define IAD_ST_COI  4
`define IAD_ST_TRC  3

// ----------------------------------------
// Event bits
// ----------------------------------------
`define IAD_EV_MATCH 0
`define IAD_EV_START 1
`define IAD_EV_STOP  2
`define IAD_EV_ALOST 3

// ----------------------------------------
// Bit counts and reset values
// ----------------------------------------
`define IAD_BIT_ADDR  4'h8
`define IAD_BIT_ACK   4'h9
`define IAD_BIT_FIRST 4'h1
`define IAD_RST_BYTE  8'h00
`define IAD_RST_EV    4'h0
`define IAD_RST_CNT   4'h0
`define IAD_RST_SHIFT 8'hff
`define IAD_RST_SYNC  3'h7

`endif

/* File: logic/iad_pkg.sv */
// Types of the address-match status block
package iad_pkg;

	// ----------------------------------------
	// Register port request
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} iad_req_t;

	// ----------------------------------------
	// Whole block state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic       en;
		logic [7:0] sva;
		logic [7:0] shift;
		logic [7:0] rx;
		logic [3:0] bcnt;
		logic       first;
		logic       coi;
		logic       trc;
		logic       ald;
		logic       msts;
		logic       drv;
		logic [3:0] ev;
		logic [3:0] msk;
		logic [7:0] rdata;
	} iad_state_t;

endpackage : iad_pkg

/* File: logic/iad_status.sv */
// Address-match and transmit-state status logic of the two-wire interface
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "iad_map.svh"

// Functional notes
// - Set address-match at eighth bus clock rise when address equals local slave address
// - Clear address-match on start or stop condition
// - Leave bit, interface-on falling, or reset clear address-match and transmit-state
// - Transmit-state zero keeps data line released
// - Transmit-state one drives shift-out latch from first byte ninth clock fall
// - Arbitration-lost rising clears transmit-state
// - Master start generation sets transmit-state
// - Master: sent direction bit zero sets, one clears transmit-state
// - Slave: received direction bit one sets, zero clears transmit-state
// - Slave: start condition clears transmit-state
// - Wait release at ninth clock with transmit-state clears it, releases line
// - Leave bit is control bit 6, interface-on is control bit 7
// - Arbitration loss sets arbitration-lost and clears master-status
module iad_status (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Register port
	input  wire iad_pkg::iad_req_t req_i,
	output logic [7:0]             rdata_o,
	// Master sequencer
	input  wire logic              mst_start_i,
	input  wire logic              arb_lost_i,
	// Bus pins
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oen_o,
	// Interrupt
	output logic                   irq_o
);
	import iad_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction : rise

	function automatic logic hit(input iad_req_t r, input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction : hit

	iad_state_t q;
	iad_state_t next_q;

	logic       scl_h;
	logic       sda_h;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       wr_ctrl;
	logic       leave;
	logic       wrel;
	logic       on_fall;
	logic       addr_done;
	logic [7:0] rx_byte;
	logic       match;
	logic [3:0] ev_set;
	logic [7:0] status_byte;
	logic [7:0] rd_sel;

	// ----------------------------------------
	// Bus condition detection
	// ----------------------------------------
	assign scl_h     = q.scl_sync[1];
	assign sda_h     = q.sda_sync[1];
	assign scl_rise  = rise(scl_h, q.scl_sync[2]);
	assign scl_fall  = rise(q.scl_sync[2], scl_h);
	assign start_det = q.en & scl_h & q.scl_sync[2] & rise(q.sda_sync[2], sda_h);
	assign stop_det  = q.en & scl_h & q.scl_sync[2] & rise(sda_h, q.sda_sync[2]);

	// ----------------------------------------
	// Software controls
	// ----------------------------------------
	assign wr_ctrl = req_i.wr & hit(req_i, `IAD_OFS_CTRL);
	assign leave   = wr_ctrl & req_i.wdata[`IAD_CTL_LEAVE];
	assign wrel    = wr_ctrl & req_i.wdata[`IAD_CTL_WREL];
	assign on_fall = wr_ctrl & q.en & ~req_i.wdata[`IAD_CTL_ON];

	// ----------------------------------------
	// Address byte decode
	// ----------------------------------------
	assign rx_byte   = {q.rx[6:0], sda_h};
	assign addr_done = q.en & scl_rise & q.first & (q.bcnt + `IAD_BIT_FIRST == `IAD_BIT_ADDR);
	assign match     = rx_byte[7:1] == q.sva[7:1];

	assign status_byte = {q.msts, q.ald, 1'b0, q.coi, q.trc, 3'h0};

	always_comb begin
		rd_sel = `IAD_RST_BYTE;
		unique case (1'b1)
			hit(req_i, `IAD_OFS_CTRL):   rd_sel = {q.en, 7'h00};
			hit(req_i, `IAD_OFS_STATUS): rd_sel = status_byte;
			hit(req_i, `IAD_OFS_SADDR):  rd_sel = q.sva;
			hit(req_i, `IAD_OFS_DATA):   rd_sel = q.shift;
			hit(req_i, `IAD_OFS_INTST):  rd_sel = {4'h0, q.ev};
			hit(req_i, `IAD_OFS_INTMSK): rd_sel = {4'h0, q.msk};
			default:                     rd_sel = `IAD_RST_BYTE;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_q = q;
		ev_set = `IAD_RST_EV;
		next_q.scl_sync = {q.scl_sync[1:0], scl_i};
		next_q.sda_sync = {q.sda_sync[1:0], sda_i};

		// Register writes; status byte has no write path
		if (wr_ctrl) begin
			next_q.en = req_i.wdata[`IAD_CTL_ON];
		end
		if (req_i.wr & hit(req_i, `IAD_OFS_SADDR)) begin
			next_q.sva = req_i.wdata;
		end
		if (req_i.wr & hit(req_i, `IAD_OFS_DATA)) begin
			next_q.shift = req_i.wdata;
		end
		if (req_i.wr & hit(req_i, `IAD_OFS_INTMSK)) begin
			next_q.msk = req_i.wdata[3:0];
		end
		if (req_i.wr & hit(req_i, `IAD_OFS_INTST)) begin
			next_q.ev = q.ev & ~req_i.wdata[3:0];
		end
		if (req_i.rd & hit(req_i, `IAD_OFS_STATUS)) begin
			next_q.ald = 1'b0;
		end
		next_q.rdata = req_i.rd ? rd_sel : `IAD_RST_BYTE;

		// Software clears
		if (leave | on_fall) begin
			next_q.coi  = 1'b0;
			next_q.trc  = 1'b0;
			next_q.msts = 1'b0;
		end
		if (on_fall) begin
			next_q.ald = 1'b0;
		end
		if (wrel) begin
			next_q.trc = 1'b0;
		end

		// Bit counting on the bus clock
		if (scl_rise) begin
			next_q.rx   = rx_byte;
			next_q.bcnt = (q.bcnt == `IAD_BIT_ACK) ? `IAD_BIT_FIRST : q.bcnt + `IAD_BIT_FIRST;
		end
		if (scl_fall) begin
			if (q.bcnt == `IAD_BIT_ACK) begin
				next_q.first = 1'b0;
			end else if ((q.bcnt != `IAD_RST_CNT) && (q.bcnt < `IAD_BIT_ADDR)) begin
				next_q.shift = {q.shift[6:0], 1'b1};
			end
		end

		// Start and stop conditions
		if (start_det) begin
			next_q.bcnt  = `IAD_RST_CNT;
			next_q.first = 1'b1;
			next_q.coi   = 1'b0;
			if (!q.msts) begin
				next_q.trc = 1'b0;
			end
			ev_set[`IAD_EV_START] = 1'b1;
		end
		if (stop_det) begin
			next_q.coi   = 1'b0;
			next_q.trc   = 1'b0;
			next_q.msts  = 1'b0;
			next_q.first = 1'b0;
			ev_set[`IAD_EV_STOP] = 1'b1;
		end

		// Address byte complete
		if (addr_done) begin
			if (q.msts) begin
				next_q.trc = ~q.shift[7];
			end else if (match) begin
				next_q.coi = 1'b1;
				next_q.trc = rx_byte[0];
				ev_set[`IAD_EV_MATCH] = 1'b1;
			end
		end

		// Arbitration loss
		if (q.en & arb_lost_i) begin
			next_q.ald  = 1'b1;
			next_q.msts = 1'b0;
			if (!q.ald) begin
				next_q.trc = 1'b0;
			end
			ev_set[`IAD_EV_ALOST] = 1'b1;
		end

		// Master start generation
		if (q.en & mst_start_i) begin
			next_q.msts = 1'b1;
			next_q.trc  = 1'b1;
		end

		// Data line driver follows transmit-state
		if (!next_q.trc) begin
			next_q.drv = 1'b0;
		end else if (scl_fall & q.first & (q.bcnt == `IAD_BIT_ACK)) begin
			next_q.drv = 1'b1;
		end

		next_q.ev = next_q.ev | ev_set;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q          <= '0;
			q.scl_sync <= `IAD_RST_SYNC;
			q.sda_sync <= `IAD_RST_SYNC;
			q.shift    <= `IAD_RST_SHIFT;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o   = q.rdata;
	assign sda_o     = q.shift[7];
	assign sda_oen_o = ~q.drv;
	assign irq_o     = |(q.ev & q.msk);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_MATCH_SET: assert property (
		addr_done && !q.msts && match && !arb_lost_i && !(leave || on_fall) |=> q.coi
	) else $error("address match flag not set");

	AST_COND_CLR: assert property (
		(start_det || stop_det) && !addr_done |=> !q.coi
	) else $error("address match flag survived bus condition");

	AST_LEAVE_CLR: assert property (
		(leave || on_fall) && !(q.en && mst_start_i) && !addr_done |=> !q.coi && !q.trc
	) else $error("leave or disable did not clear flags");

	AST_RX_RELEASE: assert property (
		!q.trc |-> sda_oen_o
	) else $error("data line driven in receive state");

	AST_STOP_TRC: assert property (
		stop_det && !(q.en && mst_start_i) |=> !q.trc ##1 sda_oen_o
	) else $error("transmit state survived stop");

	AST_ALOST: assert property (
		q.en && arb_lost_i && !q.ald && !mst_start_i |=> !q.trc && !q.msts && q.ald
	) else $error("arbitration loss handling wrong");

	AST_MSTART: assert property (
		q.en && mst_start_i |=> q.trc && q.msts
	) else $error("master start did not set transmit state");

	AST_SLAVE_DIR: assert property (
		addr_done && !q.msts && match && !arb_lost_i && !mst_start_i && !wrel && !leave && !on_fall
		|=> q.trc == $past(sda_h)
	) else $error("slave direction bit not taken");

	AST_WREL: assert property (
		wrel && q.trc && !(q.en && mst_start_i) |=> !q.trc && sda_oen_o
	) else $error("wait release did not release line");

	AST_RO_STATUS: assert property (
		req_i.wr && hit(req_i, `IAD_OFS_STATUS) && !start_det && !stop_det && !addr_done
		&& !arb_lost_i && !mst_start_i |=> $stable(q.coi) && $stable(q.trc)
	) else $error("status write altered flags");

	AST_ENABLE: assert property (
		wr_ctrl |=> q.en == $past(req_i.wdata[`IAD_CTL_ON])
	) else $error("interface-on bit not taken");

	// ----------------------------------------
	// Driver, direction, flag and read-back checks
	// ----------------------------------------

	AST_TX_DRIVE: assert property (
		q.trc && scl_fall && q.first && (q.bcnt == `IAD_BIT_ACK) && !wrel && !leave && !on_fall
		&& !(q.en && arb_lost_i && !q.ald) |=> !sda_oen_o
	) else $error("data line not driven after first ninth clock");

	AST_EARLY_DRIVE: assert property (
		sda_oen_o && !(scl_fall && q.first && (q.bcnt == `IAD_BIT_ACK)) |=> sda_oen_o
	) else $error("data line driven before first ninth clock");

	AST_MASTER_DIR: assert property (
		addr_done && q.msts && !arb_lost_i && !mst_start_i && !wrel && !leave && !on_fall
		|=> q.trc == !$past(q.shift[7])
	) else $error("master direction bit not taken");

	AST_SLAVE_START: assert property (
		start_det && !q.msts && !(q.en && mst_start_i) |=> !q.trc
	) else $error("slave transmit state survived start");

	AST_ARB_MSTS: assert property (
		q.en && arb_lost_i && !mst_start_i |=> q.ald && !q.msts
	) else $error("arbitration loss kept master status");

	AST_ALD_READ: assert property (
		req_i.rd && hit(req_i, `IAD_OFS_STATUS) && !(q.en && arb_lost_i) |=> !q.ald
	) else $error("arbitration lost flag survived status read");

	AST_MATCH_MISS: assert property (
		addr_done && (!match || q.msts) && !leave && !on_fall
		|=> $stable(q.coi)
	) else $error("address match flag changed without match");

	AST_OFF_QUIET: assert property (
		!q.en && !leave |=> $stable(q.coi) && $stable(q.msts)
	) else $error("flags changed while interface off");

	AST_STATUS_READ: assert property (
		req_i.rd && hit(req_i, `IAD_OFS_STATUS)
		|=> rdata_o[`IAD_ST_COI] == $past(q.coi) && rdata_o[`IAD_ST_TRC] == $past(q.trc)
	) else $error("status read did not show flags");

	AST_RDATA_IDLE: assert property (
		!req_i.rd |=> rdata_o == `IAD_RST_BYTE
	) else $error("read data not idle");

endmodule : iad_status

/* File: tb/iad_bus_host.sv */
// Two-wire bus master model driving the clock and data lines
`timescale 1ns/1ps
module iad_bus_host (
	// Bus lines, open drain with pull-up
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic start();
		#13 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#80 sda_o = 1'b0;
		#80 scl_o = 1'b0;
	endtask : start

	task automatic clk_bit(input logic b);
		#40 sda_o = b;
		#120 scl_o = 1'b1;
		#160 scl_o = 1'b0;
	endtask : clk_bit

	task automatic send8(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i]);
		end
	endtask : send8

	// Ninth clock with the line released to the pull-up
	task automatic ninth();
		#13 clk_bit(1'b1);
	endtask : ninth

	task automatic stop();
		#53 sda_o = 1'b0;
		#120 scl_o = 1'b1;
		#80 sda_o = 1'b1;
	endtask : stop
endmodule : iad_bus_host

/* File: tb/iad_status_tb_top.sv */
// Self-checking bench of the address-match status block
`timescale 1ns/1ps
`include "iad_map.svh"
module iad_status_tb_top;
	import iad_pkg::*;
	logic       clk_i;
	logic       rst_i;
	iad_req_t   req_i;
	logic [7:0] rdata_o;
	logic       mst_start_i;
	logic       arb_lost_i;
	logic       scl_w;
	logic       bh_sda;
	logic       sda_w;
	logic       sda_o;
	logic       sda_oen_o;
	logic       irq_o;
	logic [6:0] sa;
	int         mismatches;
	int         cmp_count;

	iad_bus_host iad_bus_host_i (.scl_o(scl_w), .sda_o(bh_sda));
	assign sda_w = bh_sda & (sda_oen_o | sda_o);
	iad_status iad_status_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
		.mst_start_i(mst_start_i), .arb_lost_i(arb_lost_i), .scl_i(scl_w), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oen_o(sda_oen_o), .irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	function automatic logic [7:0] st(input logic ms, al, co, tr);
		return {ms, al, 1'b0, co, tr, 3'b000};
	endfunction : st

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) req_i <= '0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i) req_i <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i) req_i <= '0;
		#1 chk(rdata_o, exp);
	endtask : rd

	task automatic settle();
		repeat (6) @(posedge clk_i);
	endtask : settle

	task automatic xfer(input logic [6:0] a, input logic d, input logic [7:0] exp);
		iad_bus_host_i.start();
		iad_bus_host_i.send8({a, d});
		settle();
		rd(`IAD_OFS_STATUS, exp);
	endtask : xfer

	task automatic pulse(input logic m);
		@(posedge clk_i) begin
			mst_start_i <= m;
			arb_lost_i  <= ~m;
		end
		@(posedge clk_i) begin
			mst_start_i <= 1'b0;
			arb_lost_i  <= 1'b0;
		end
		settle();
	endtask : pulse

	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic setup();
		wr(`IAD_OFS_CTRL, 8'h80);
		wr(`IAD_OFS_SADDR, {sa, 1'b0});
		wr(`IAD_OFS_INTMSK, 8'h0f);
	endtask : setup

	initial begin
		#1_000_000;
		mismatches++;
		finish_test();
	end

	initial begin
		void'($urandom(15));
		rst_i = 1'b1;
		req_i = '0;
		mst_start_i = 1'b0;
		arb_lost_i = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		sa = 7'($urandom);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk({6'h00, irq_o, sda_oen_o}, 8'h01);
		setup();
		xfer(sa, 1'b1, st(0, 0, 1, 1));
		chk({7'h00, sda_oen_o}, 8'h01);
		rd(`IAD_OFS_INTST, 8'h03);
		chk({7'h00, irq_o}, 8'h01);
		wr(`IAD_OFS_INTMSK, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		wr(`IAD_OFS_INTMSK, 8'h0f);
		wr(`IAD_OFS_INTST, 8'h0f);
		chk({7'h00, irq_o}, 8'h00);
		wr(`IAD_OFS_DATA, {1'b0, 7'($urandom)});
		iad_bus_host_i.ninth();
		settle();
		chk({6'h00, sda_oen_o, sda_o}, 8'h00);
		wr(`IAD_OFS_STATUS, 8'hff);
		rd(`IAD_OFS_STATUS, st(0, 0, 1, 1));
		wr(`IAD_OFS_CTRL, 8'ha0);
		rd(`IAD_OFS_STATUS, st(0, 0, 1, 0));
		chk({7'h00, sda_oen_o}, 8'h01);
		iad_bus_host_i.stop();
		settle();
		rd(`IAD_OFS_STATUS, 8'h00);
		xfer(sa ^ 7'(1 + $urandom % 127), 1'b1, 8'h00);
		iad_bus_host_i.stop();
		xfer(sa, 1'b0, st(0, 0, 1, 0));
		iad_bus_host_i.start();
		settle();
		rd(`IAD_OFS_STATUS, 8'h00);
		iad_bus_host_i.stop();
		xfer(sa, 1'b1, st(0, 0, 1, 1));
		wr(`IAD_OFS_CTRL, 8'hc0);
		rd(`IAD_OFS_STATUS, 8'h00);
		iad_bus_host_i.stop();
		xfer(sa, 1'b1, st(0, 0, 1, 1));
		wr(`IAD_OFS_CTRL, 8'h00);
		rd(`IAD_OFS_STATUS, 8'h00);
		iad_bus_host_i.stop();
		wr(`IAD_OFS_CTRL, 8'h80);
		xfer(sa, 1'b1, st(0, 0, 1, 1));
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`IAD_OFS_STATUS, 8'h00);
		iad_bus_host_i.stop();
		setup();
		pulse(1'b1);
		rd(`IAD_OFS_STATUS, st(1, 0, 0, 1));
		pulse(1'b0);
		rd(`IAD_OFS_STATUS, st(0, 1, 0, 0));
		rd(`IAD_OFS_STATUS, 8'h00);
		pulse(1'b1);
		wr(`IAD_OFS_DATA, {7'($urandom), 1'b0});
		xfer(sa ^ 7'h01, 1'b0, st(1, 0, 0, 1));
		pulse(1'b1);
		wr(`IAD_OFS_DATA, 8'hff);
		xfer(sa ^ 7'h01, 1'b1, st(1, 0, 0, 0));
		iad_bus_host_i.stop();
		settle();
		rd(`IAD_OFS_STATUS, 8'h00);
		rd(`IAD_OFS_CTRL + 8'h10, 8'h00);
		finish_test();
	end
endmodule : iad_status_tb_top
